// ### core/serial_load_if.sv
// serial pins in, decoded buffer loads out
`timescale 1ns/10ps
interface serial_load_if;
    import synth_pkg::*;
    logic            sdata;
    logic            sclk;
    logic            sen;
    logic            ld_valid;
    logic [1:0]      ld_code;
    logic [FW_W-1:0] ld_data;
    modport src (input sdata, sclk, sen, output ld_valid, ld_code, ld_data);
    modport dst (output sdata, sclk, sen, input ld_valid, ld_code, ld_data);
endinterface

// ### core/serial_loader.sv
// three-wire shift register and buffer transfer decode
`timescale 1ns/10ps
module serial_loader
    import synth_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    serial_load_if.src sl
);
    logic [SR_W-1:0] sr;
    logic            sclk_q;
    logic            sen_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr     <= '0;
            sclk_q <= 1'b0;
            sen_q  <= 1'b0;
        end else begin
            sclk_q <= sl.sclk;
            sen_q  <= sl.sen;
            if (sl.sen && sl.sclk && !sclk_q) begin
                sr <= {sr[SR_W-2:0], sl.sdata};
            end
        end
    end

    // shorter frames simply leave their data right-aligned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sl.ld_valid <= 1'b0;
            sl.ld_code  <= CODE_F1;
            sl.ld_data  <= '0;
        end else begin
            sl.ld_valid <= sen_q && !sl.sen;
            if (sen_q && !sl.sen) begin
                sl.ld_code <= sr[1:0];
                sl.ld_data <= sr[SR_W-1:2];
            end
        end
    end

    a_load_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        sen_q && !sl.sen |=> sl.ld_valid && sl.ld_code == $past(sr[1:0]))
        else $error("buffer transfer missed chip enable fall");
endmodule

// ### core/synth_core.sv
// synthesiser divider chain, serial word storage and pump enables
`timescale 1ns/10ps
// What this block does
// - select high uses word one, low two
// - serial load works during power down
// - low pump bit gates divider output taps
// - 00 both pumps on, 01 pump one off
// - high bit: lock cuts pump one; two on
// - out of lock re-enables pump one
// - chain divides by M times N plus A
// - prescaler pair 16/17 or 8/9
// - one reference bit picks the pair
// - four-bit swallow counter, counts then stops
// - swallow running holds modulus N+1
// - fifteen-bit main counter from active word
// - counters reload every main cycle
// - 8/9 uses three swallow bits
// - thirteen-bit reference divider, 1 to 8191
// - reference output feeds phase comparator
// - gain field scales pump two
// - msb first, transfer on enable fall
// - final code picks buffer to load
// - reference word fields: ratio, pumps, prescaler
// - frequency word: counts, gain, sense
module synth_core
    import synth_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        rf_i,
    input  wire logic        xtal_i,
    input  wire logic        ser_data_i,
    input  wire logic        ser_clk_i,
    input  wire logic        ser_en_i,
    input  wire logic        freq_word_select_i,
    input  wire logic        power_down_i,
    input  wire logic        lock_i,
    output logic             pump1_en_o,
    output logic             pump2_en_o,
    output logic [1:0]       pump2_gain_o,
    output logic             pd_ref_o,
    output logic             pd_vco_o,
    output logic             ref_tap_o,
    output logic             vco_divider_tap_o
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [SY_N-1:0] raw;
    logic [SY_N-1:0] sy1;
    logic [SY_N-1:0] sy;

    assign raw = {lock_i, power_down_i, freq_word_select_i, ser_en_i,
                  ser_clk_i, ser_data_i, xtal_i, rf_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sy1 <= '0;
            sy  <= '0;
        end else begin
            sy1 <= raw;
            sy  <= sy1;
        end
    end

    // ----------------------------------------
    // serial loader
    // ----------------------------------------
    serial_load_if sl ();

    assign sl.sdata = sy[SY_SDAT];
    assign sl.sclk  = sy[SY_SCLK];
    assign sl.sen   = sy[SY_SEN];

    serial_loader u_loader (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sl    (sl)
    );

    // ----------------------------------------
    // word buffers
    // ----------------------------------------
    logic [FW_W-1:0] freq_word_one;
    logic [FW_W-1:0] freq_word_two;
    logic [RW_W-1:0] ref_cfg;
    logic            act_sel;
    logic            wide;
    logic [FW_W-1:0] act;
    logic [FW_W-1:0] act_a_upd;

    assign wide = !ref_cfg[RW_PRE];
    assign act  = act_sel ? freq_word_one : freq_word_two;

    // only the swallow field of the active word is touched
    always_comb begin
        act_a_upd = act;
        if (wide) begin
            act_a_upd[A_W-1:0] = sl.ld_data[A_W-1:0];
        end else begin
            act_a_upd[A_W8-1:0] = sl.ld_data[A_W8-1:0];
        end
    end

    // loads are never gated by power down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_word_one <= FW_RST;
            freq_word_two <= FW_RST;
            ref_cfg       <= RW_RST;
        end else if (sl.ld_valid) begin
            case (sl.ld_code)
                CODE_F1: begin
                    freq_word_one <= sl.ld_data;
                end
                CODE_F2: begin
                    freq_word_two <= sl.ld_data;
                end
                CODE_A: begin
                    if (act_sel) begin
                        freq_word_one <= act_a_upd;
                    end else begin
                        freq_word_two <= act_a_upd;
                    end
                end
                CODE_REF: begin
                    ref_cfg <= sl.ld_data[RW_W-1:0];
                end
                default: begin
                    ref_cfg <= ref_cfg;
                end
            endcase
        end
    end

    // ----------------------------------------
    // control register and run state
    // ----------------------------------------
    logic ctrl_pdn;
    logic run;
    logic lock_s;

    assign run    = !(ctrl_pdn || sy[SY_PDN]);
    assign lock_s = sy[SY_LOCK];

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    logic [A_W-1:0] a_val;
    logic [M_W-1:0] m_val;
    logic [4:0]     pre_n;

    always_comb begin
        if (wide) begin
            a_val = act[A_W-1:0];
            m_val = act[M_LO16 +: M_W];
            pre_n = PRE_N16;
        end else begin
            // the bit left over stays zero by convention
            a_val = {1'b0, act[A_W8-1:0]};
            m_val = act[M_LO8 +: M_W];
            pre_n = PRE_N8;
        end
    end

    // ----------------------------------------
    // prescaler and swallow counter
    // ----------------------------------------
    logic           rf_q;
    logic           xtal_q;
    logic           rf_tick;
    logic           xtal_tick;
    logic [4:0]     pre_cnt;
    logic [4:0]     pre_mod;
    logic           pre_tick;
    logic [A_W-1:0] a_cnt;
    logic [M_W-1:0] m_ratio;
    logic           m_end;
    logic           r_end;

    assign rf_tick   = run && sy[SY_RF] && !rf_q;
    assign xtal_tick = run && sy[SY_XTAL] && !xtal_q;
    assign pre_mod   = (a_cnt != '0) ? pre_n + 5'h01 : pre_n;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rf_q   <= 1'b0;
            xtal_q <= 1'b0;
        end else begin
            rf_q   <= sy[SY_RF];
            xtal_q <= sy[SY_XTAL];
        end
    end

    // one prescaler period per modulus rf edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt  <= '0;
            pre_tick <= 1'b0;
        end else begin
            pre_tick <= 1'b0;
            if (!run) begin
                pre_cnt <= '0;
            end else if (rf_tick) begin
                if (pre_cnt == pre_mod - 5'h01) begin
                    pre_cnt  <= '0;
                    pre_tick <= 1'b1;
                end else begin
                    pre_cnt <= pre_cnt + 5'h01;
                end
            end
        end
    end

    // reload on the main boundary; idle chain follows at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_cnt   <= '0;
            m_ratio <= '0;
            act_sel <= 1'b1;
        end else if (m_end || !run) begin
            a_cnt   <= a_val;
            m_ratio <= m_val;
            act_sel <= sy[SY_SEL];
        end else if (pre_tick && a_cnt != '0) begin
            a_cnt <= a_cnt - A_W'(1);
        end
    end

    tick_divider #(
        .W (M_W)
    ) u_main (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (pre_tick),
        .ratio_i (m_ratio),
        .end_o   (m_end)
    );

    tick_divider #(
        .W (REF_W)
    ) u_ref (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (xtal_tick),
        .ratio_i (ref_cfg[REF_W-1:0]),
        .end_o   (r_end)
    );

    // ----------------------------------------
    // comparator feeds, taps and pump enables
    // ----------------------------------------
    logic sense;

    assign sense = act[FW_SENSE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_ref_o          <= 1'b0;
            pd_vco_o          <= 1'b0;
            ref_tap_o         <= 1'b0;
            vco_divider_tap_o <= 1'b0;
            pump2_gain_o      <= '0;
        end else begin
            pd_ref_o          <= sense ? m_end : r_end;
            pd_vco_o          <= sense ? r_end : m_end;
            ref_tap_o         <= ref_cfg[RW_PLO] && (sense ? m_end : r_end);
            vco_divider_tap_o <= ref_cfg[RW_PLO] && (sense ? r_end : m_end);
            pump2_gain_o      <= act[FW_GAIN +: GAIN_W];
        end
    end

    // the lock path only matters with the high bit set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pump1_en_o <= 1'b0;
            pump2_en_o <= 1'b0;
        end else begin
            pump2_en_o <= run;
            if (!run) begin
                pump1_en_o <= 1'b0;
            end else if (ref_cfg[RW_PHI]) begin
                pump1_en_o <= !lock_s;
            end else begin
                pump1_en_o <= !ref_cfg[RW_PLO];
            end
        end
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    logic bus_req;

    assign bus_req = cyc_i && stb_i && !ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o    <= 1'b0;
            dat_o    <= '0;
            ctrl_pdn <= 1'b0;
        end else begin
            ack_o <= bus_req;
            if (bus_req && we_i && sel_i[0] && adr_i == ADR_CTRL) begin
                ctrl_pdn <= dat_i[CTRL_PDN];
            end
            if (bus_req && !we_i) begin
                case (adr_i)
                    ADR_STATUS: dat_o <= {26'h0, pump2_en_o, pump1_en_o,
                                          lock_s, act_sel, wide, !run};
                    ADR_CTRL:   dat_o <= {31'h0, ctrl_pdn};
                    ADR_FW1:    dat_o <= {10'h0, freq_word_one};
                    ADR_FW2:    dat_o <= {10'h0, freq_word_two};
                    ADR_REF:    dat_o <= {16'h0, ref_cfg};
                    default:    dat_o <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ref_frame;
        sl.ld_valid && sl.ld_code == CODE_REF;
    endsequence

    sequence s_ref_stored;
        ref_cfg == $past(sl.ld_data[RW_W-1:0]);
    endsequence

    a_taps_gated: assert property (!ref_cfg[RW_PLO] |=> !ref_tap_o && !vco_divider_tap_o)
        else $error("divider tap driven with low pump bit clear");
    // sampled reset keeps the edge of release from expecting the reset values to be on
    a_pumps_both_on: assert property (!rst_i && run && !ref_cfg[RW_PHI] && !ref_cfg[RW_PLO]
        |=> pump1_en_o && pump2_en_o)
        else $error("pumps not both on in setting 00");
    a_pump1_off: assert property (!ref_cfg[RW_PHI] && ref_cfg[RW_PLO] |=> !pump1_en_o)
        else $error("pump one on in setting 01");
    a_lock_cuts_pump: assert property (ref_cfg[RW_PHI] && lock_s |=> !pump1_en_o)
        else $error("pump one on while locked");
    a_acquire_both: assert property (run && ref_cfg[RW_PHI] && !lock_s
        |=> pump1_en_o && pump2_en_o)
        else $error("pump one off while out of lock");
    a_swallow_count: assert property (pre_tick && !m_end && a_cnt != '0 && run
        |=> a_cnt == $past(a_cnt) - A_W'(1))
        else $error("swallow counter did not step");
    a_select_boundary: assert property (m_end |=> act_sel == $past(sy[SY_SEL]))
        else $error("select not taken at main reload");
    // both stages are flushed by reset, so skip the two edges that follow it
    a_lock_sync: assert property (!rst_i && !$past(rst_i) && !$past(rst_i, 2)
        |-> lock_s == $past(lock_i, 2))
        else $error("lock not two stages behind its pin");
    a_ref_load: assert property (s_ref_frame |=> s_ref_stored)
        else $error("reference word not stored");
endmodule

// ### core/synth_pkg.sv
// shared constants for the synthesiser divider control core
package synth_pkg;
    // ----------------------------------------
    // serial frame layout
    // ----------------------------------------
    localparam int SR_W = 24;
    localparam int FW_W = 22;
    localparam int RW_W = 16;
    localparam logic [1:0] CODE_F1  = 2'h0;
    localparam logic [1:0] CODE_F2  = 2'h2;
    localparam logic [1:0] CODE_A   = 2'h1;
    localparam logic [1:0] CODE_REF = 2'h3;
    // ----------------------------------------
    // frequency word fields
    // ----------------------------------------
    localparam int FW_SENSE = 21;
    localparam int FW_GAIN  = 19;
    localparam int GAIN_W   = 2;
    localparam int A_W      = 4;
    localparam int A_W8     = 3;
    localparam int M_W      = 15;
    localparam int M_LO16   = 4;
    localparam int M_LO8    = 3;
    // ----------------------------------------
    // reference word fields
    // ----------------------------------------
    localparam int REF_W   = 13;
    localparam int RW_PLO  = 13;
    localparam int RW_PHI  = 14;
    localparam int RW_PRE  = 15;
    localparam logic [4:0] PRE_N16 = 5'h10;
    localparam logic [4:0] PRE_N8  = 5'h08;
    localparam logic [FW_W-1:0] FW_RST = 22'h000000;
    localparam logic [RW_W-1:0] RW_RST = 16'h0001;
    // ----------------------------------------
    // bus map
    // ----------------------------------------
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_CTRL   = 8'h04;
    localparam logic [7:0] ADR_FW1    = 8'h08;
    localparam logic [7:0] ADR_FW2    = 8'h0C;
    localparam logic [7:0] ADR_REF    = 8'h10;
    localparam int CTRL_PDN = 0;
    // ----------------------------------------
    // pin synchroniser slots
    // ----------------------------------------
    localparam int SY_RF   = 0;
    localparam int SY_XTAL = 1;
    localparam int SY_SDAT = 2;
    localparam int SY_SCLK = 3;
    localparam int SY_SEN  = 4;
    localparam int SY_SEL  = 5;
    localparam int SY_PDN  = 6;
    localparam int SY_LOCK = 7;
    localparam int SY_N    = 8;
endpackage

// ### core/tick_divider.sv
// programmable divider of a one-cycle tick stream
`timescale 1ns/10ps
module tick_divider #(
    parameter int W = 13
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] ratio_i,
    output logic              end_o
);
    logic [W-1:0] cnt;

    generate
        if (W < 2) begin : g_chk
            $error("tick_divider width too small");
        end
    endgenerate

    // ratio 0 behaves as 1 so the chain never stalls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt   <= '0;
            end_o <= 1'b0;
        end else begin
            end_o <= 1'b0;
            if (tick_i) begin
                if (cnt + W'(1) >= ratio_i) begin
                    cnt   <= '0;
                    end_o <= 1'b1;
                end else begin
                    cnt <= cnt + W'(1);
                end
            end
        end
    end
endmodule

// ### tb/serial_host.sv
// controlling processor model driving the three-wire programming pins
`timescale 1ns/10ps
module serial_host (
    input  wire logic clk_i,
    output logic      ser_data_o,
    output logic      ser_clk_o,
    output logic      ser_en_o
);
    initial begin
        ser_data_o = 1'b0;
        ser_clk_o  = 1'b0;
        ser_en_o   = 1'b0;
    end
    // ----------------------------------------
    // frame shifting
    // ----------------------------------------
    // five system clocks per half period gives the 80 ns link clock
    task automatic half();
        repeat (5) @(posedge clk_i);
    endtask
    // link clock stands low outside frames; data shows the inverse once released
    task automatic shift_bits(input logic [23:0] v, input int n);
        ser_en_o <= 1'b1;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            ser_data_o <= v[i];
            half();
            ser_clk_o <= 1'b1;
            half();
            ser_clk_o <= 1'b0;
        end
        half();
        ser_en_o   <= 1'b0;
        ser_data_o <= ~v[0];
        half();
    endtask
    task automatic send_freq(input logic [21:0] d, input logic [1:0] code);
        shift_bits({2'h0, d, code}, 24);
    endtask
    task automatic send_ref(input logic [15:0] d);
        shift_bits({6'h00, d, 2'h3}, 18);
    endtask
endmodule

// ### tb/testbench.sv
// self-checking bench for the synthesiser divider control core
`timescale 1ns/10ps
module testbench;
    import synth_pkg::*;
    typedef struct packed {
        logic        is_ref;
        logic [1:0]  code;
        logic [21:0] data;
        logic [7:0]  adr;
        logic [31:0] exp;
    } frame_row_s;
    logic        clk_i              = 1'b0;
    logic        rst_i              = 1'b1;
    logic [7:0]  adr_i              = 8'h00;
    logic [31:0] dat_i              = 32'h00000000;
    logic        we_i               = 1'b0;
    logic [3:0]  sel_i              = 4'hF;
    logic        cyc_i              = 1'b0;
    logic        stb_i              = 1'b0;
    logic        rf_i               = 1'b0;
    logic        xtal_i             = 1'b0;
    logic        freq_word_select_i = 1'b1;
    logic        power_down_i       = 1'b0;
    logic        lock_i             = 1'b0;
    logic        ser_data_i;
    logic        ser_clk_i;
    logic        ser_en_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        pump1_en_o;
    logic        pump2_en_o;
    logic [1:0]  pump2_gain_o;
    logic        pd_ref_o;
    logic        pd_vco_o;
    logic        ref_tap_o;
    logic        vco_divider_tap_o;
    int          miscompares        = 0;
    int          num_checks         = 0;
    int          cycles             = 0;

    synth_core synth_core_inst (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .rf_i(rf_i), .xtal_i(xtal_i), .ser_data_i(ser_data_i), .ser_clk_i(ser_clk_i),
        .ser_en_i(ser_en_i), .freq_word_select_i(freq_word_select_i),
        .power_down_i(power_down_i), .lock_i(lock_i), .pump1_en_o(pump1_en_o),
        .pump2_en_o(pump2_en_o), .pump2_gain_o(pump2_gain_o), .pd_ref_o(pd_ref_o),
        .pd_vco_o(pd_vco_o), .ref_tap_o(ref_tap_o), .vco_divider_tap_o(vco_divider_tap_o));
    serial_host serial_host_inst (
        .clk_i(clk_i), .ser_data_o(ser_data_i), .ser_clk_o(ser_clk_i), .ser_en_o(ser_en_i));

    always #4 clk_i = ~clk_i;
    // rf period 8 clocks, crystal period 6 clocks: both hold each level for at least 3 clocks
    always begin
        repeat (4) @(posedge clk_i);
        rf_i <= ~rf_i;
    end
    always begin
        repeat (3) @(posedge clk_i);
        xtal_i <= ~xtal_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // bus, compare and measure tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // classic cycle: request held until ack is sampled, then released for a cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i  <= w;
        dat_i <= d;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) begin
            miscompares++;
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        wb(a, 1'b0, 32'h00000000, q);
        check(name, q, exp);
    endtask
    // third gap returned: the first after reprogramming may still run the old word
    task automatic gap(input logic vco, output int len);
        for (int k = 0; k < 3; k++) begin
            len = 0;
            do begin
                @(posedge clk_i);
                len++;
            end while ((vco ? pd_vco_o : pd_ref_o) !== 1'b1 && len < 3000);
        end
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        frame_row_s  rows [5];
        logic [31:0] q;
        int          len;
        int          nref;
        int          ntap;
        int          nvt;
        rows = '{'{1'b0, CODE_F1, 22'h2ABCDE, ADR_FW1, 32'h002ABCDE},
                 '{1'b0, CODE_F2, 22'h15432A, ADR_FW2, 32'h0015432A},
                 '{1'b1, CODE_REF, 22'h002007, ADR_REF, 32'h00002007},
                 '{1'b0, CODE_A, 22'h000009, ADR_FW1, 32'h002ABCD9},
                 '{1'b0, CODE_F2, 22'h3FFFFF, ADR_FW2, 32'h003FFFFF}};
        repeat (3) @(posedge clk_i);
        check("ack in reset", ack_o, 1'b0);
        check("pump two in reset", pump2_en_o, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        check("pump one after reset", pump1_en_o, 1'b1);
        check("pump two after reset", pump2_en_o, 1'b1);
        rd(ADR_STATUS, 32'h00000036, "status");
        rd(ADR_REF, 32'h00000001, "ref reset");
        rd(8'h20, 32'h00000000, "unmapped");
        $display("reset test done");
        foreach (rows[i]) begin
            if (rows[i].is_ref) begin
                serial_host_inst.send_ref(rows[i].data[15:0]);
            end else begin
                serial_host_inst.send_freq(rows[i].data, rows[i].code);
            end
            rd(rows[i].adr, rows[i].exp, "frame word");
        end
        $display("frame table done");
        // the table leaves a huge main count running; short word plus power down reloads it
        serial_host_inst.send_freq(22'h000010, CODE_F1);
        power_down_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        power_down_i <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            serial_host_inst.send_ref({1'b0, s[1:0], 13'h0001});
            for (int lk = 0; lk < 2; lk++) begin
                lock_i <= lk[0];
                nref = 0;
                ntap = 0;
                nvt  = 0;
                repeat (60) begin
                    @(posedge clk_i);
                    nref += pd_ref_o;
                    ntap += ref_tap_o;
                    nvt  += (vco_divider_tap_o !== (s[0] && pd_vco_o));
                end
                check("vco taps", nvt, 0);
                check("pump one", pump1_en_o, s[1] ? !lk[0] : !s[0]);
                check("pump two", pump2_en_o, 1'b1);
                check("ref taps", ntap, s[0] ? nref : 0);
                check("ref pulses", nref == 10, 1'b1);
            end
        end
        $display("pump setting test done");
        serial_host_inst.send_ref(16'h0005);
        serial_host_inst.send_freq(22'h080032, CODE_F1);
        serial_host_inst.send_freq(22'h100032, CODE_F2);
        gap(1'b1, len);
        check("vco period 16", len, 400);
        gap(1'b0, len);
        check("ref period", len, 30);
        check("gain word one", pump2_gain_o, 2'h1);
        freq_word_select_i <= 1'b0;
        gap(1'b1, len);
        check("gain word two", pump2_gain_o, 2'h2);
        serial_host_inst.send_ref(16'h8005);
        serial_host_inst.send_freq(22'h10001A, CODE_F2);
        gap(1'b1, len);
        check("vco period 8", len, 208);
        serial_host_inst.send_freq(22'h000005, CODE_A);
        rd(ADR_FW2, 32'h0010001D, "narrow swallow load");
        serial_host_inst.send_freq(22'h30001A, CODE_F2);
        gap(1'b0, len);
        check("sense swap", len, 208);
        $display("divider test done");
        power_down_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check("pump one down", pump1_en_o, 1'b0);
        check("pump two down", pump2_en_o, 1'b0);
        serial_host_inst.send_freq(22'h0ABCDE, CODE_F1);
        rd(ADR_FW1, 32'h000ABCDE, "load in power down");
        power_down_i <= 1'b0;
        wb(ADR_CTRL, 1'b1, 32'h00000001, q);
        repeat (4) @(posedge clk_i);
        check("pump two soft down", pump2_en_o, 1'b0);
        rd(ADR_CTRL, 32'h00000001, "ctrl");
        wb(ADR_CTRL, 1'b1, 32'h00000000, q);
        wb(8'h20, 1'b1, 32'hFFFFFFFF, q);
        rd(8'h20, 32'h00000000, "unmapped write");
        $display("power down test done");
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(ADR_REF, 32'h00000001, "ref second reset");
        rd(ADR_FW1, 32'h00000000, "word one second reset");
        $display("second reset test done");
        give_verdict();
    end
endmodule
